/* File: isolator_pkg.sv */
// package: mode encoding, switch bundle, timing constants for the direction control
`default_nettype none
package isolator_pkg;
   typedef enum logic [1:0] {MODE_P2P, MODE_BUS4, MODE_BUS2} line_mode_t;

   typedef struct packed {
      logic duplex_select_switch;
      logic bus_mode_select_switch;
      logic fixed_cfg_switch_a;
      logic fixed_cfg_switch_b;
      logic fixed_cfg_switch_c;
      logic hold_time_select_switch;
   } switch_set_t;

   typedef struct packed {
      logic data;
      logic handshake;
   } chan_t;

   localparam int unsigned CLK_FREQ_HZ = 40_000_000;
   localparam int unsigned HOLD_SHORT_US = 10;
   localparam int unsigned HOLD_LONG_US = 50;
   localparam int unsigned HOLD_SHORT_CYC = (HOLD_SHORT_US * CLK_FREQ_HZ) / 1_000_000;
   localparam int unsigned HOLD_LONG_CYC = (HOLD_LONG_US * CLK_FREQ_HZ) / 1_000_000;
   localparam int unsigned HOLD_CNT_W = 12;
   localparam logic DATA_IDLE_LEVEL = 1'b1;
   localparam logic DRV_EN_RESET = 1'b0;
endpackage : isolator_pkg
`default_nettype wire

/* File: rs485_auto_direction_isolator.sv */
// module: mode decode and automatic driver direction control of one isolator side
`timescale 1ns/1ps
`default_nettype none

// How it works
// - point-to-point: data and handshake both ways, drivers and receivers always on
// - bus modes: one data channel per direction, handshake not carried
// - bus modes: driver turns on by itself when outgoing data starts
// - after activity ends, driver stays on for hold time, then high impedance
// - four-wire bus: receive channel always enabled
// - two-wire bus: receiver off while driver on, on when driver off
// - hold time 10 us with hold switch on, 50 us with it off
// - duplex/bus switches decode the mode; fixed switches read off, on, off
module rs485_auto_direction_isolator
   import isolator_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input var switch_set_t switches,
   input var chan_t link_tx,
   input var chan_t line_rx,
   output var chan_t line_tx,
   output logic line_drv_en,
   output logic line_rcv_en,
   output var chan_t link_rx,
   output var line_mode_t mode,
   output logic cfg_fault
);

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic rst_meta_r;
   logic rst_sync_b_r;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_meta_r <= 1'b0;
         rst_sync_b_r <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_sync_b_r <= rst_meta_r;
      end
   end

   // ------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------
   function automatic line_mode_t decode_mode(input switch_set_t s);
      if (!s.bus_mode_select_switch)
         decode_mode = MODE_P2P;
      else if (s.duplex_select_switch)
         decode_mode = MODE_BUS2;
      else
         decode_mode = MODE_BUS4;
   endfunction : decode_mode

   line_mode_t mode_nxt;
   logic fault_nxt;

   always_comb
   begin
      mode_nxt = decode_mode(switches);
      fault_nxt = switches.fixed_cfg_switch_a || !switches.fixed_cfg_switch_b ||
         switches.fixed_cfg_switch_c || (switches.duplex_select_switch &&
         !switches.bus_mode_select_switch);
   end

   always_ff @(posedge clk or negedge rst_sync_b_r)
   begin
      if (!rst_sync_b_r)
      begin
         mode <= MODE_P2P;
         cfg_fault <= 1'b0;
      end
      else
      begin
         mode <= mode_nxt;
         cfg_fault <= fault_nxt;
      end
   end

   // ------------------------------------------------------------
   // hold timer and driver enable
   // ------------------------------------------------------------
   logic [HOLD_CNT_W-1:0] hold_cnt_r;
   logic [HOLD_CNT_W-1:0] hold_load;
   logic active;
   logic bus_mode;
   logic drv_nxt;

   assign active = (link_tx.data != DATA_IDLE_LEVEL);
   assign bus_mode = (mode_nxt != MODE_P2P);
   assign hold_load = switches.hold_time_select_switch ?
      HOLD_CNT_W'(HOLD_SHORT_CYC) : HOLD_CNT_W'(HOLD_LONG_CYC);

   always_ff @(posedge clk or negedge rst_sync_b_r)
   begin
      if (!rst_sync_b_r)
         hold_cnt_r <= '0;
      else if (!bus_mode)
         hold_cnt_r <= '0;
      else if (active)
         hold_cnt_r <= hold_load;
      else if (hold_cnt_r != '0)
         hold_cnt_r <= hold_cnt_r - 1'b1;
   end

   // driver on during activity and while hold count is above one
   assign drv_nxt = !bus_mode || active || (hold_cnt_r > HOLD_CNT_W'(1));

   always_ff @(posedge clk or negedge rst_sync_b_r)
   begin
      if (!rst_sync_b_r)
      begin
         line_drv_en <= DRV_EN_RESET;
         line_rcv_en <= 1'b1;
      end
      else
      begin
         line_drv_en <= drv_nxt;
         line_rcv_en <= (mode_nxt != MODE_BUS2) || !drv_nxt;
      end
   end

   // ------------------------------------------------------------
   // data path
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_sync_b_r)
   begin
      if (!rst_sync_b_r)
      begin
         line_tx <= '{data: DATA_IDLE_LEVEL, handshake: DATA_IDLE_LEVEL};
         link_rx <= '{data: DATA_IDLE_LEVEL, handshake: DATA_IDLE_LEVEL};
      end
      else
      begin
         line_tx.data <= link_tx.data;
         link_rx.data <= (mode_nxt == MODE_BUS2 && drv_nxt) ? DATA_IDLE_LEVEL :
            line_rx.data;
         line_tx.handshake <= bus_mode ? DATA_IDLE_LEVEL : link_tx.handshake;
         link_rx.handshake <= bus_mode ? DATA_IDLE_LEVEL : line_rx.handshake;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_sync_b_r);

   sequence s_quiet_bus;
      !active && bus_mode && $stable(mode_nxt) && $stable(hold_load);
   endsequence

   sequence s_drive_start;
      active && bus_mode && $stable(mode_nxt);
   endsequence

   sequence s_driving;
      line_drv_en && bus_mode;
   endsequence

   a_p2p_always_on: assert property ($past(rst_sync_b_r) && mode == MODE_P2P
      && $past(mode_nxt) == MODE_P2P |-> line_drv_en && line_rcv_en)
      else $error("driver or receiver off in point-to-point");
   a_bus_no_hs: assert property (bus_mode |=> link_rx.handshake == DATA_IDLE_LEVEL
      && line_tx.handshake == DATA_IDLE_LEVEL)
      else $error("handshake passed in bus mode");
   a_drv_on_start: assert property (active |=> line_drv_en)
      else $error("driver not enabled on activity");
   a_hold_short: assert property (active && switches.hold_time_select_switch ##1
      s_quiet_bus [*8] |-> line_drv_en)
      else $error("driver released early");
   a_hold_release: assert property (hold_cnt_r == HOLD_CNT_W'(1) && !active && bus_mode
      |=> !line_drv_en)
      else $error("driver not released after hold");
   a_bus4_rcv: assert property (mode_nxt == MODE_BUS4 |=> line_rcv_en)
      else $error("receiver off in four-wire mode");
   a_bus2_excl: assert property (mode == MODE_BUS2 && $past(mode_nxt) == MODE_BUS2
      |-> line_rcv_en != line_drv_en)
      else $error("two-wire receiver and driver not exclusive");
   a_restart: assert property (bus_mode && active |=> hold_cnt_r == hold_load
      || !bus_mode || $changed(switches))
      else $error("hold timer not restarted");
   a_mode_dec: assert property (switches.bus_mode_select_switch &&
      !switches.duplex_select_switch |=> mode == MODE_BUS4)
      else $error("mode decode wrong");
   a_data_pass: assert property (1'b1 |=> line_tx.data == $past(link_tx.data))
      else $error("data not passed through");
   a_drv_seq: assert property (s_drive_start |=> s_driving)
      else $error("driver not on after activity in bus mode");
   a_bus2_rcv_off: assert property (mode_nxt == MODE_BUS2 && active |=> !line_rcv_en)
      else $error("two-wire receiver on while driving");
   a_bus2_rcv_back: assert property (mode_nxt == MODE_BUS2 && !active
      && hold_cnt_r <= HOLD_CNT_W'(1) |=> line_rcv_en)
      else $error("two-wire receiver not back after release");
   a_bus2_rx_idle: assert property (mode_nxt == MODE_BUS2 && active
      |=> link_rx.data == DATA_IDLE_LEVEL)
      else $error("two-wire receive data not gated while driving");
   a_bus4_rx_pass: assert property (mode_nxt == MODE_BUS4
      |=> link_rx.data == $past(line_rx.data))
      else $error("four-wire receive data not passed");
   a_p2p_hs_pass: assert property (mode_nxt == MODE_P2P |=> line_tx.handshake ==
      $past(link_tx.handshake) && link_rx.handshake == $past(line_rx.handshake))
      else $error("handshake not passed in point-to-point");
   a_hold_count: assert property (bus_mode && !active && hold_cnt_r > HOLD_CNT_W'(1)
      |=> hold_cnt_r == $past(hold_cnt_r) - HOLD_CNT_W'(1))
      else $error("hold timer not counting down");
   a_hold_long: assert property (bus_mode && active && !switches.hold_time_select_switch
      |=> hold_cnt_r == HOLD_CNT_W'(HOLD_LONG_CYC))
      else $error("long hold time not loaded");
   a_cfg_fault: assert property (switches.fixed_cfg_switch_a |=> cfg_fault)
      else $error("fixed switch fault not flagged");
   a_mode_bus2: assert property (switches.bus_mode_select_switch
      && switches.duplex_select_switch |=> mode == MODE_BUS2)
      else $error("two-wire mode decode wrong");

endmodule : rs485_auto_direction_isolator

`default_nettype wire

/* File: bus_node.sv */
// far-side bus node model that drives the receive pair of the isolator
`timescale 1ns/1ps
`default_nettype none
module bus_node
   import isolator_pkg::*;
(
   input wire logic clk,
   input wire logic talk,
   output var chan_t line_rx
);
   logic [1:0] pat_r = 2'h0;
   // a silent bus rests at idle through the termination network
   always_ff @(posedge clk)
   begin
      pat_r <= pat_r + 2'h1;
      line_rx <= talk ? chan_t'(pat_r) : chan_t'(2'h3);
   end
endmodule : bus_node
`default_nettype wire

/* File: testbench.sv */
// testbench: mode decode and automatic driver direction of one side
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import isolator_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic talk = 1'b0;
   switch_set_t switches = 6'h05;
   chan_t link_tx = 2'h3;
   chan_t line_rx, line_tx, link_rx, rx_seen;
   logic line_drv_en, line_rcv_en, cfg_fault;
   line_mode_t mode;
   int err_total = 0;
   int checked = 0;
   always #12.5 clk = ~clk;
   always @(posedge clk) rx_seen <= line_rx;
   bus_node partner (.clk(clk), .talk(talk), .line_rx(line_rx));
   rs485_auto_direction_isolator uut (.clk(clk), .rst_b(rst_b), .switches(switches),
      .link_tx(link_tx), .line_rx(line_rx), .line_tx(line_tx), .line_drv_en(line_drv_en),
      .line_rcv_en(line_rcv_en), .link_rx(link_rx), .mode(mode), .cfg_fault(cfg_fault));
   // ----------
   // checks
   // ----------
   task chk(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task tally_and_finish;
      $display("err_total=%0d checked=%0d", err_total, checked);
      if (err_total == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   task set_mode(input switch_set_t sw);
      @(negedge clk) switches = sw;
      repeat (3) @(negedge clk);
   endtask : set_mode
   task pulse;
      link_tx = 2'h0;
      @(negedge clk) link_tx = 2'h3;
   endtask : pulse
   task p2p_test;
      int i;
      set_mode(6'h05);
      talk = 1'b1;
      for (i = 0; i < 4; i++)
      begin
         link_tx = chan_t'(i);
         @(negedge clk);
         chk(line_tx, i[1:0]);
         chk({mode, line_drv_en, line_rcv_en, cfg_fault}, {MODE_P2P, 3'b110});
         chk(link_rx, rx_seen);
      end
      talk = 1'b0;
   endtask : p2p_test
   task bus_test(input switch_set_t sw, input line_mode_t m, input int cyc);
      int n;
      logic two;
      two = (m == MODE_BUS2);
      set_mode(sw);
      talk = 1'b1;
      @(negedge clk);
      chk({mode, line_drv_en, link_rx.handshake}, {m, 2'b01});
      talk = 1'b0;
      pulse();
      chk({line_drv_en, line_rcv_en, line_tx}, {1'b1, ~two, 2'h1});
      talk = 1'b1;
      repeat (4)
      begin
         @(negedge clk);
         chk(link_rx.data, two ? DATA_IDLE_LEVEL : rx_seen.data);
      end
      talk = 1'b0;
      repeat (100) @(negedge clk);
      chk({line_drv_en, line_rcv_en}, {1'b1, ~two});
      pulse();
      n = 0;
      while (line_drv_en === 1'b1 && n < 3000)
      begin
         @(negedge clk);
         n++;
      end
      chk(n >= cyc - 2 && n <= cyc + 2, 1'b1);
      chk(line_rcv_en, 1'b1);
   endtask : bus_test
   initial
   begin
      repeat (16) @(negedge clk);
      chk({line_drv_en, line_rcv_en}, 2'b01);
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
      p2p_test();
      bus_test(6'h15, MODE_BUS4, HOLD_SHORT_CYC);
      bus_test(6'h34, MODE_BUS2, HOLD_LONG_CYC);
      set_mode(6'h01);
      chk(cfg_fault, 1'b1);
      set_mode(6'h25);
      chk({mode, cfg_fault}, {MODE_P2P, 1'b1});
      tally_and_finish();
   end
   // tests need under 4000 cycles; the watchdog allows 40000
   initial
   begin
      #1000000;
      err_total++;
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
